// File: logic/mss_cas_map.sv
// Column strobe lane mapping, active high, for one DRAM column phase.
// Assumes all inputs come from logic on the same clock; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none
`include "mss_map.svh"

module mss_cas_map
    import mss_pkg::*;
(
    input  wire logic [`MSS_LANES-1:0] lane_en,    // Byte lanes in use, active high
    input  wire logic                  interleave, // Interleaved DRAM mapping
    input  wire logic                  leaf_odd,   // Odd leaf selected
    input  wire logic                  col_phase,  // Column address is on the bus
    input  wire logic                  refresh,    // Refresh cycle in progress
    output logic      [`MSS_CAS_W-1:0] cas_on      // Column strobes, active high
);

    genvar i;
    generate
        for (i = 0; i < `MSS_LANES; i = i + 1) begin : g_lane
            wire logic lo_sel;
            wire logic hi_sel;
            assign lo_sel = interleave ? ~leaf_odd : 1'b1;
            assign hi_sel = interleave ?  leaf_odd : 1'b1;
            assign cas_on[i]              = refresh | (col_phase & lane_en[i] & lo_sel);
            assign cas_on[i+`MSS_LANES]   = refresh | (col_phase & lane_en[i] & hi_sel);
        end
    endgenerate

endmodule
`default_nettype wire

// File: logic/mss_map.svh
// Constants for the memory strobe select block: widths, counts and idle levels.
// Assumes it is included by bare name from files under logic/.
`ifndef MSS_MAP_SVH
`define MSS_MAP_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define MSS_MA_W        12
`define MSS_LANES       4
`define MSS_CAS_W       8
`define MSS_RAS_W       4
`define MSS_BEAT_W      2

// ****************************************************************
// Idle levels and counts
// ****************************************************************
`define MSS_CAS_IDLE    8'hFF
`define MSS_RAS_IDLE    4'hF
`define MSS_CE_IDLE     2'h3
`define MSS_DALE_IDLE   2'h0
`define MSS_LEAF_IDLE   2'h3
`define MSS_MA_RESET    12'h000
`define MSS_BEAT_ZERO   2'h0
`define MSS_ADDR_STEP   12'h001

`endif

// File: logic/mss_pkg.sv
// Types for the memory strobe select block.
// Assumes the constants header is compiled alongside.
package mss_pkg;

    // ****************************************************************
    // Sequencer states, Gray coded along idle-row-column-release
    // ****************************************************************
    typedef enum logic [2:0] {
        MSS_IDLE = 3'h0,
        MSS_ROW  = 3'h1,
        MSS_COL  = 3'h3,
        MSS_REL  = 3'h2,
        MSS_BANK = 3'h6,
        MSS_REF  = 3'h7
    } mss_state_t;

endpackage

// File: logic/mss_strobe_select.sv
// Memory strobe select: sequences row, column, bank enable and leaf strobes.
// Assumes access requests come from the memory controller core on the same clock.
//
// Contract
// - Outside refresh cycles, column strobes are asserted only while the muxed address shows a column address.
// - A refresh cycle asserts all eight column strobes together.
// - Interleaved mode uses strobes 0-3 for the even leaf and 4-7 for the odd leaf.
// - Bank 0 accesses assert bank select 0 and bank 1 accesses assert bank select 1.
// - The two bank selects are never asserted in the same cycle.
// - A bank select stays asserted without a gap until its access completes.
// - Leaf address latch enables pulse only for interleaved DRAM accesses.
// - Latch enable 0 marks an even-leaf address and latch enable 1 an odd-leaf address.
// - A row strobe is asserted with the row address and released after the last transfer.
// - Interleaved reads assert leaf output enable 0 for even and 1 for odd leaf.
// - Bank accesses drive word address bits 13:2, stepping once per burst transfer.
`timescale 1ns/100ps
`default_nettype none
`include "mss_map.svh"

module mss_strobe_select
    import mss_pkg::*;
(
    input  wire logic                  clock,                // 250 MHz local bus clock
    input  wire logic                  rst_n,                // Synchronous reset, active low
    input  wire logic                  start_dram,           // Pulse: begin a DRAM access
    input  wire logic                  start_bank,           // Pulse: begin a bank access
    input  wire logic                  refresh_req,          // Pulse: run a refresh cycle
    input  wire logic                  interleave_cfg,       // Interleaved DRAM arrangement
    input  wire logic                  leaf_odd,             // Access targets the odd leaf
    input  wire logic                  access_read,          // Access is a read
    input  wire logic [1:0]            dram_bank,            // DRAM bank index
    input  wire logic                  mem_bank,             // SRAM/flash/ROM bank index
    input  wire logic [`MSS_BEAT_W-1:0] beats_minus1,        // Transfers in burst minus one
    input  wire logic [`MSS_MA_W-1:0]  row_addr,             // Row address
    input  wire logic [`MSS_MA_W-1:0]  col_addr,             // First column address
    input  wire logic [`MSS_MA_W-1:0]  bank_word_addr,       // Address bits 13:2
    input  wire logic [`MSS_LANES-1:0] byte_lane_enable_n,   // Byte lane enables, active low
    output logic      [`MSS_CAS_W-1:0] column_strobe_n,      // Column strobes, active low
    output logic      [`MSS_RAS_W-1:0] row_strobe_n,         // Row strobes, active low
    output logic      [1:0]            bank_select_n,        // Bank chip enables, active low
    output logic      [1:0]            leaf_addr_latch_en,   // Leaf address latch enables
    output logic      [1:0]            leaf_output_enable_n, // Leaf read output enables
    output logic      [`MSS_MA_W-1:0]  muxed_mem_addr,       // Multiplexed address
    output logic                       busy,                 // Access in progress
    output logic                       done                  // Pulse: access finished
);

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    function automatic logic [1:0] leaf_onehot(input logic odd);
        leaf_onehot = odd ? 2'h2 : 2'h1;
    endfunction

    // ****************************************************************
    // State and captured access attributes
    // ****************************************************************
    mss_state_t                state_reg;
    mss_state_t                state_next;
    logic                      mode_reg;
    logic                      leaf_reg;
    logic                      read_reg;
    logic [1:0]                dbank_reg;
    logic                      mbank_reg;
    logic [`MSS_LANES-1:0]     lane_reg;
    logic [`MSS_BEAT_W-1:0]    beats_reg;
    logic [`MSS_MA_W-1:0]      col_reg;
    logic [`MSS_MA_W-1:0]      baddr_reg;

    wire logic                 in_idle;
    wire logic                 take;
    wire logic                 last_beat;
    wire logic                 mode_next;
    wire logic                 leaf_next;
    wire logic                 read_next;
    wire logic [1:0]           dbank_next;
    wire logic                 mbank_next;
    wire logic [`MSS_LANES-1:0] lane_next;
    wire logic [`MSS_BEAT_W-1:0] beats_next;
    wire logic [`MSS_MA_W-1:0] col_next;
    wire logic [`MSS_MA_W-1:0] baddr_next;

    assign in_idle   = (state_reg == MSS_IDLE);
    assign take      = in_idle & (start_dram | start_bank) & ~refresh_req;
    assign last_beat = (beats_reg == `MSS_BEAT_ZERO);

    assign mode_next  = take ? interleave_cfg : mode_reg;
    assign leaf_next  = take ? leaf_odd : leaf_reg;
    assign read_next  = take ? access_read : read_reg;
    assign dbank_next = take ? dram_bank : dbank_reg;
    assign mbank_next = take ? mem_bank : mbank_reg;
    assign lane_next  = take ? ~byte_lane_enable_n : lane_reg;

    // Burst counters step only while a transfer phase repeats.
    wire logic stepping;
    assign stepping   = ((state_reg == MSS_COL) | (state_reg == MSS_BANK)) & ~last_beat;
    assign beats_next = take ? beats_minus1 :
                        stepping ? beats_reg - 2'h1 : beats_reg;
    assign col_next   = take ? col_addr :
                        (stepping & (state_reg == MSS_COL)) ? col_reg + `MSS_ADDR_STEP
                                                            : col_reg;
    assign baddr_next = take ? bank_word_addr :
                        (stepping & (state_reg == MSS_BANK)) ? baddr_reg + `MSS_ADDR_STEP
                                                             : baddr_reg;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        case (state_reg)
            MSS_IDLE: begin
                if (refresh_req) begin
                    state_next = MSS_REF;
                end else if (start_dram) begin
                    state_next = MSS_ROW;
                end else if (start_bank) begin
                    state_next = MSS_BANK;
                end else begin
                    state_next = MSS_IDLE;
                end
            end
            MSS_ROW:  state_next = MSS_COL;
            MSS_COL:  state_next = last_beat ? MSS_REL : MSS_COL;
            MSS_REL:  state_next = MSS_IDLE;
            MSS_BANK: state_next = last_beat ? MSS_IDLE : MSS_BANK;
            MSS_REF:  state_next = MSS_REL;
            default:  state_next = MSS_IDLE;
        endcase
    end

    // ****************************************************************
    // Output next values, decoded from the next state; done from the current state
    // ****************************************************************
    wire logic                  nx_row;
    wire logic                  nx_col;
    wire logic                  nx_bank;
    wire logic                  nx_ref;
    wire logic [`MSS_CAS_W-1:0] cas_on;
    wire logic [`MSS_RAS_W-1:0] ras_on;
    wire logic [1:0]            leaf_sel;
    wire logic [`MSS_CAS_W-1:0] cas_n_next;
    wire logic [`MSS_RAS_W-1:0] ras_n_next;
    wire logic [1:0]            ce_n_next;
    wire logic [1:0]            dale_next;
    wire logic [1:0]            leaf_oe_n_next;
    wire logic [`MSS_MA_W-1:0]  ma_next;
    wire logic                  done_next;

    assign nx_row   = (state_next == MSS_ROW);
    assign nx_col   = (state_next == MSS_COL);
    assign nx_bank  = (state_next == MSS_BANK);
    assign nx_ref   = (state_next == MSS_REF);
    assign leaf_sel = leaf_onehot(leaf_next);

    mss_cas_map u_cas_map (
        .lane_en    (lane_next),
        .interleave (mode_next),
        .leaf_odd   (leaf_next),
        .col_phase  (nx_col),
        .refresh    (nx_ref),
        .cas_on     (cas_on)
    );

    // row strobe until last transfer
    // Interleaved pairs share the bank's upper index bit; the leaf select, not the lower bank bit, picks the strobe in the pair.
    assign ras_on = nx_ref ? 4'hF :
                    ~(nx_row | nx_col) ? 4'h0 :
                    mode_next ? (4'h1 << {dbank_next[1], leaf_next})
                              : (4'h1 << dbank_next);

    assign cas_n_next = ~cas_on;
    assign ras_n_next = ~ras_on;
    assign ce_n_next  = nx_bank ? ~leaf_onehot(mbank_next) : `MSS_CE_IDLE;
    assign dale_next  = (mode_next & (nx_row | nx_col)) ? leaf_sel : `MSS_DALE_IDLE;
    assign leaf_oe_n_next = (mode_next & read_next & nx_col) ? ~leaf_sel : `MSS_LEAF_IDLE;

    // The address holds its last value between accesses so latches see no glitch.
    assign ma_next = nx_row  ? row_addr :
                     nx_col  ? col_next :
                     nx_bank ? baddr_next : muxed_mem_addr;

    assign done_next = ((state_reg == MSS_REL) & ~nx_row) |
                       ((state_reg == MSS_BANK) & last_beat);

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= MSS_IDLE;
            mode_reg  <= 1'b0;
            leaf_reg  <= 1'b0;
            read_reg  <= 1'b0;
            dbank_reg <= 2'h0;
            mbank_reg <= 1'b0;
            lane_reg  <= 4'h0;
            beats_reg <= `MSS_BEAT_ZERO;
            col_reg   <= `MSS_MA_RESET;
            baddr_reg <= `MSS_MA_RESET;
        end else begin
            state_reg <= state_next;
            mode_reg  <= mode_next;
            leaf_reg  <= leaf_next;
            read_reg  <= read_next;
            dbank_reg <= dbank_next;
            mbank_reg <= mbank_next;
            lane_reg  <= lane_next;
            beats_reg <= beats_next;
            col_reg   <= col_next;
            baddr_reg <= baddr_next;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            column_strobe_n      <= `MSS_CAS_IDLE;
            row_strobe_n         <= `MSS_RAS_IDLE;
            bank_select_n        <= `MSS_CE_IDLE;
            leaf_addr_latch_en   <= `MSS_DALE_IDLE;
            leaf_output_enable_n <= `MSS_LEAF_IDLE;
            muxed_mem_addr       <= `MSS_MA_RESET;
            busy                 <= 1'b0;
            done                 <= 1'b0;
        end else begin
            column_strobe_n      <= cas_n_next;
            row_strobe_n         <= ras_n_next;
            bank_select_n        <= ce_n_next;
            leaf_addr_latch_en   <= dale_next;
            leaf_output_enable_n <= leaf_oe_n_next;
            muxed_mem_addr       <= ma_next;
            busy                 <= (state_next != MSS_IDLE);
            done                 <= done_next;
        end
    end

endmodule
`default_nettype wire

// File: tb/mss_mem_model.sv
// Memory chips as seen from the strobes: they take row and column addresses.
// Assumes active low strobes that change just after the rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module mss_mem_model (
    input  wire logic        clock,           // Clock
    input  wire logic [7:0]  column_strobe_n, // Column strobes
    input  wire logic [3:0]  row_strobe_n,    // Row strobes
    input  wire logic [11:0] muxed_mem_addr,  // Address
    output logic      [11:0] row_seen,        // Row taken at strobe fall
    output logic      [11:0] col_seen         // Last column taken
);
    // ********
    // Capture
    // ********
    logic row_open_reg;
    always_ff @(posedge clock) begin
        row_open_reg <= row_strobe_n != 4'hF;
        if (row_strobe_n != 4'hF && !row_open_reg) begin
            row_seen <= muxed_mem_addr;
        end
        if (column_strobe_n != 8'hFF) begin
            col_seen <= muxed_mem_addr;
        end
    end
endmodule
`default_nettype wire

// File: tb/mss_sva.sv
// Port checks for the memory strobe select block.
// Assumes it is bound to that module and shares its clock and reset.
`timescale 1ns/100ps
`default_nettype none
module mss_sva (
    input wire logic        clock,              // Clock
    input wire logic        rst_n,              // Reset
    input wire logic        start_dram,         // DRAM start
    input wire logic        start_bank,         // Bank start
    input wire logic        refresh_req,        // Refresh
    input wire logic        mem_bank,           // Bank index
    input wire logic        busy,               // Busy
    input wire logic        done,               // Done
    input wire logic [7:0]  column_strobe_n,    // Column strobes
    input wire logic [3:0]  row_strobe_n,       // Row strobes
    input wire logic [1:0]  bank_select_n,      // Bank selects
    input wire logic [1:0]  leaf_addr_latch_en, // Latch enables
    input wire logic [11:0] muxed_mem_addr      // Address
);
    // ********
    // Checks
    // ********
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_ref; refresh_req && !busy |=> column_strobe_n == 8'h00; endproperty
    a_ref: assert property (p_ref) else $error("refresh strobes");
    property p_pair; leaf_addr_latch_en == 2'b00 |-> column_strobe_n[3:0] == column_strobe_n[7:4];
    endproperty
    a_pair: assert property (p_pair) else $error("strobe pairing");
    property p_leaf; (!leaf_addr_latch_en[0] || &column_strobe_n[7:4])
        && (!leaf_addr_latch_en[1] || &column_strobe_n[3:0]); endproperty
    a_leaf: assert property (p_leaf) else $error("leaf strobe half");
    property p_sel; start_bank && !start_dram && !refresh_req && !busy
        |=> bank_select_n == {!mem_bank, mem_bank}; endproperty
    a_sel: assert property (p_sel) else $error("bank select");
    property p_excl; bank_select_n != 2'b00; endproperty
    a_excl: assert property (p_excl) else $error("both banks");
    property p_hold; bank_select_n != 2'b11 |=> $stable(bank_select_n) || done; endproperty
    a_hold: assert property (p_hold) else $error("bank select gap");
    property p_step; bank_select_n != 2'b11 && bank_select_n == $past(bank_select_n)
        |-> muxed_mem_addr == $past(muxed_mem_addr) + 12'h001; endproperty
    a_step: assert property (p_step) else $error("bank address step");
    property p_idle; !busy |-> column_strobe_n == 8'hFF && row_strobe_n == 4'hF
        && bank_select_n == 2'b11 && leaf_addr_latch_en == 2'b00; endproperty
    a_idle: assert property (p_idle) else $error("strobe while idle");
    c_ref: cover property (refresh_req && !busy ##1 row_strobe_n == 4'h0);
    c_bank: cover property (bank_select_n == 2'b01 ##1 bank_select_n == 2'b01);
    c_odd: cover property (leaf_addr_latch_en == 2'b10);
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the memory strobe select block.
// Assumes the design under logic/ and the model and checker under tb/.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ********
    // Bench
    // ********
    logic clock, rst_n, start_dram, start_bank, refresh_req, interleave_cfg;
    logic leaf_odd, access_read, mem_bank, busy, done;
    logic [1:0] dram_bank, beats_minus1, bank_select_n, leaf_addr_latch_en, leaf_output_enable_n;
    logic [3:0] byte_lane_enable_n, row_strobe_n;
    logic [7:0] column_strobe_n;
    logic [11:0] row_addr, col_addr, bank_word_addr, muxed_mem_addr, row_seen, col_seen;
    int bad_count = 0;
    int cmp_count = 0;
    mss_strobe_select u_dut (.clock, .rst_n, .start_dram, .start_bank, .refresh_req,
        .interleave_cfg, .leaf_odd, .access_read, .dram_bank, .mem_bank, .beats_minus1,
        .row_addr, .col_addr, .bank_word_addr, .byte_lane_enable_n, .column_strobe_n,
        .row_strobe_n, .bank_select_n, .leaf_addr_latch_en, .leaf_output_enable_n,
        .muxed_mem_addr, .busy, .done);
    mss_mem_model u_mem (.clock, .column_strobe_n, .row_strobe_n, .muxed_mem_addr,
        .row_seen, .col_seen);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick;
        @(posedge clock);
        #1;
    endtask
    task automatic launch(input logic [2:0] k);
        {start_dram, start_bank, refresh_req} = k;
        tick();
        {start_dram, start_bank, refresh_req} = 3'b000;
    endtask
    task automatic dram_run(input logic il, input logic odd, input logic [3:0] be);
        logic [7:0] col_exp;
        logic [3:0] row_exp;
        logic [1:0] lat_exp;
        logic [1:0] oe_exp;
        col_exp = !il ? {be, be} : (odd ? {be, 4'hF} : {4'hF, be});
        lat_exp = !il ? 2'b00 : (odd ? 2'b10 : 2'b01);
        oe_exp = (il && access_read) ? ~lat_exp : 2'b11;
        row_exp = ~(4'h1 << (il ? {dram_bank[1], odd} : dram_bank));
        {interleave_cfg, leaf_odd, byte_lane_enable_n} = {il, odd, be};
        launch(3'b100);
        interleave_cfg = !il;
        chk("dram busy", 1'b1, busy);
        chk("row strobe", row_exp, row_strobe_n);
        chk("row address", row_addr, muxed_mem_addr);
        chk("latch enable", lat_exp, leaf_addr_latch_en);
        chk("column early", 8'hFF, column_strobe_n);
        start_bank = 1'b1;
        tick();
        start_bank = 1'b0;
        chk("column strobe", col_exp, column_strobe_n);
        chk("column address", col_addr, muxed_mem_addr);
        chk("leaf enable", oe_exp, leaf_output_enable_n);
        tick();
        chk("column kept", col_exp, column_strobe_n);
        chk("column step", col_addr + 12'h001, muxed_mem_addr);
        chk("bank refused", 2'b11, bank_select_n);
        tick();
        chk("release row", 4'hF, row_strobe_n);
        tick();
        chk("dram done", 1'b1, done);
        chk("dram idle", 1'b0, busy);
        chk("model row", row_addr, row_seen);
        chk("model column", col_addr + 12'h001, col_seen);
    endtask
    task automatic sc_reset;
        chk("reset column", 8'hFF, column_strobe_n);
        chk("reset bank", 2'b11, bank_select_n);
        chk("reset address", 12'h000, muxed_mem_addr);
    endtask
    task automatic sc_lanes;
        for (int i = 0; i < 4; i++) begin
            dram_bank = 2'(i);
            dram_run(1'b0, i[0], 4'(~(4'h1 << i)));
        end
    endtask
    task automatic sc_leaves;
        dram_bank = 2'b10;
        dram_run(1'b1, 1'b0, 4'h5);
        dram_run(1'b1, 1'b1, 4'hA);
        access_read = 1'b0;
        dram_run(1'b1, 1'b1, 4'h3);
    endtask
    task automatic sc_refresh;
        launch(3'b111);
        chk("refresh column", 8'h00, column_strobe_n);
        tick();
        tick();
        chk("refresh done", 1'b1, done);
    endtask
    task automatic sc_bank;
        logic [1:0] sel_exp;
        beats_minus1 = 2'h3;
        for (int b = 0; b < 2; b++) begin
            mem_bank = b[0];
            sel_exp = b[0] ? 2'b01 : 2'b10;
            launch(3'b010);
            for (int j = 0; j < 4; j++) begin
                chk("bank select", sel_exp, bank_select_n);
                chk("bank address", bank_word_addr + 12'(j), muxed_mem_addr);
                tick();
            end
            chk("bank end", 2'b11, bank_select_n);
            chk("bank done", 1'b1, done);
        end
    endtask
    task automatic close_out;
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        {start_dram, start_bank, refresh_req, interleave_cfg, leaf_odd, mem_bank} = '0;
        {access_read, dram_bank, beats_minus1, byte_lane_enable_n} = 9'h11F;
        {row_addr, col_addr, bank_word_addr} = {12'h0A5, 12'h1C3, 12'h3FE};
        repeat (2) @(posedge clock);
        #1;
        rst_n = 1'b1;
        sc_reset();
        sc_lanes();
        sc_leaves();
        sc_refresh();
        sc_bank();
        close_out();
    end
    // Far beyond the 50 or so cycles (about 200 ns) the scenarios need.
    initial begin
        #20000;
        bad_count++;
        close_out();
    end
endmodule
bind mss_strobe_select mss_sva u_sva (.clock, .rst_n, .start_dram, .start_bank, .refresh_req,
    .mem_bank, .busy, .done, .column_strobe_n, .row_strobe_n, .bank_select_n,
    .leaf_addr_latch_en, .muxed_mem_addr);
`default_nettype wire
